// >>> src/pdcs_pkg.sv
// Shared constants, types and decode functions of the device control bank.
package pdcs_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   localparam logic [11:0] OFF_DEV_CTRL = 12'h048;
   localparam logic [11:0] OFF_DEV_STAT = 12'h04A;
   localparam logic [11:0] OFF_ERR_MASK = 12'h060;
   localparam logic [11:0] OFF_DBG_CTRL = 12'h062;

   localparam int CTL_CE_EN_BIT  = 0;
   localparam int CTL_NFE_EN_BIT = 1;
   localparam int CTL_FE_EN_BIT  = 2;
   localparam int CTL_UR_EN_BIT  = 3;
   localparam int CTL_RO_BIT     = 4;
   localparam int CTL_MPS_LSB    = 5;
   localparam int CTL_MPS_MSB    = 7;
   localparam int CTL_ETAG_BIT   = 8;
   localparam int CTL_PHANTOM_FUNCTION_ENABLE_BIT   = 9;
   localparam int CTL_AUXPM_BIT  = 10;
   localparam int CTL_NS_BIT     = 11;
   localparam int CTL_MAX_READ_REQUEST_SIZE_LSB   = 12;
   localparam int CTL_MAX_READ_REQUEST_SIZE_MSB   = 14;
   localparam int STS_ERR_LSB    = 0;
   localparam int STS_ERR_MSB    = 3;
   localparam int STS_AUX_POWER_DETECTED_BIT  = 4;
   localparam int STS_TP_BIT     = 5;
   localparam int DBG_SEQUENTIAL_TAG_DEBUG_BIT = 0;

   localparam logic [3:0]  ERR_EN_RST   = 4'h0;
   localparam logic [2:0]  MPS_RST      = 3'h0;
   localparam logic        ETAG_RST     = 1'b0;
   localparam logic [3:0]  ERR_STS_RST  = 4'h0;
   localparam logic [3:0]  ERR_MASK_RST = 4'h0;
   localparam logic        SEQUENTIAL_TAG_DEBUG_RST   = 1'b0;
   localparam logic [15:0] RDATA_RST    = 16'h0000;

   localparam logic [2:0]  MPS_MAX_CODE = 3'h4;
   localparam logic [11:0] MPS_BASE     = 12'h080;
   localparam logic [11:0] ORIG_MAX_RD  = 12'h080;
   localparam logic [7:0]  TAG_MAX_STD  = 8'h1F;
   localparam logic [7:0]  TAG_MAX_EXT  = 8'hFF;
   localparam logic [7:0]  TAG_RST      = 8'h00;

   typedef struct packed {
      logic unsupported;
      logic fatal;
      logic nonfatal;
      logic correctable;
   } pdcs_err_s;

   typedef struct packed {
      logic       relaxed_ordering;
      logic       no_snoop;
      logic [9:0] length_dw;
   } pdcs_attr_s;

   // Reserved payload codes fall back to the smallest payload.
   function automatic logic [11:0] pdcs_mps_bytes(input logic [2:0] code);
      if (code > MPS_MAX_CODE) begin
         return MPS_BASE;
      end
      return MPS_BASE << code;
   endfunction : pdcs_mps_bytes

   function automatic logic [7:0] pdcs_tag_limit(input logic ext);
      return ext ? TAG_MAX_EXT : TAG_MAX_STD;
   endfunction : pdcs_tag_limit

endpackage : pdcs_pkg

// >>> src/pdcs_tag_gen.sv
// Sequential debug tag generator steered by the extended tag enable.
`timescale 1ns/10ps
module pdcs_tag_gen (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       seq_en,
   input  wire logic       ext_en,
   input  wire logic       advance,
   output logic [7:0]      tag
);
   import pdcs_pkg::*;

   logic [7:0] tag_reg;
   logic [7:0] tag_next;
   logic [7:0] limit;

   always_comb begin
      limit    = pdcs_tag_limit(ext_en);
      tag_next = tag_reg;
      if (!seq_en) begin
         tag_next = TAG_RST;
      end else if (tag_reg > limit) begin
         // Narrowing the range mid-run must not leak an out-of-range tag.
         tag_next = TAG_RST;
      end else if (advance) begin
         tag_next = (tag_reg == limit) ? TAG_RST : tag_reg + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tag_reg <= TAG_RST;
      end else begin
         tag_reg <= tag_next;
      end
   end

   assign tag = tag_reg;

endmodule : pdcs_tag_gen

// >>> src/pdcs_regs.sv
// Device control and device status register bank of one switch port.
//
// Overview of operation
// - Control bits 0-3 gate reports of the four error classes, reset zero.
// - Relaxed ordering enable reads zero; originated requests never set it.
// - Payload size field bits 7:5 selects 128 to 2048 bytes, reset zero.
// - Payload codes 5, 6 and 7 behave exactly as 128 bytes.
// - With sequential tag debug on, tags run 0-31, or 0-255 when extended.
// - Extended tag enable at bit 8 is read-write, resets zero.
// - Phantom function enable at bit 9 always reads zero.
// - Aux power management enable at bit 10 always reads zero.
// - No snoop enable reads zero; never originated, forwarded unchanged.
// - Read request size reads zero; originate 128 bytes, forward as is.
// - Status bits 0-3 log errors whatever the enables; writing one clears.
// - Status bit 3 sets on an unsupported request, resets zero.
// - Aux power detected status bit 4 always reads zero.
// - Transactions pending status bit 5 always reads zero.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module pdcs_regs (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [pdcs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [pdcs_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [pdcs_pkg::DATA_W-1:0]     reg_rdata,
   input  wire pdcs_pkg::pdcs_err_s        err_detect,
   output pdcs_pkg::pdcs_err_s             err_report,
   output logic                            irq,
   output logic [11:0]                     max_payload_bytes,
   output logic [11:0]                     orig_max_read_bytes,
   output logic                            orig_relaxed_ordering,
   output logic                            orig_no_snoop,
   input  wire logic                       tag_advance,
   output logic [7:0]                      tag,
   input  wire logic                       fwd_valid,
   input  wire pdcs_pkg::pdcs_attr_s       fwd_attr_in,
   output logic                            fwd_valid_out,
   output pdcs_pkg::pdcs_attr_s            fwd_attr_out
);
   import pdcs_pkg::*;

   logic [3:0]  err_en_reg;
   logic [2:0]  mps_reg;
   logic        etag_reg;
   logic [3:0]  err_sts_reg;
   logic [3:0]  err_sts_next;
   logic [3:0]  err_mask_reg;
   logic        sequential_tag_debug_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [15:0] ctrl_view;
   logic [15:0] stat_view;
   pdcs_err_s   err_report_reg;
   logic [11:0] mps_bytes_reg;
   logic        fwd_valid_reg;
   pdcs_attr_s  fwd_attr_reg;

   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_dbg;

   assign wr_ctrl = reg_wr && (reg_addr == OFF_DEV_CTRL);
   assign wr_stat = reg_wr && (reg_addr == OFF_DEV_STAT);
   assign wr_mask = reg_wr && (reg_addr == OFF_ERR_MASK);
   assign wr_dbg  = reg_wr && (reg_addr == OFF_DBG_CTRL);

   // Only the writable fields are stored; fixed fields never get a flop.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_en_reg <= ERR_EN_RST;
         mps_reg    <= MPS_RST;
         etag_reg   <= ETAG_RST;
      end else if (wr_ctrl) begin
         err_en_reg <= reg_wdata[CTL_UR_EN_BIT:CTL_CE_EN_BIT];
         mps_reg    <= reg_wdata[CTL_MPS_MSB:CTL_MPS_LSB];
         etag_reg   <= reg_wdata[CTL_ETAG_BIT];
      end
   end

   // A detection in the same cycle as a clearing write survives it.
   always_comb begin
      err_sts_next = err_sts_reg;
      if (wr_stat) begin
         err_sts_next = err_sts_reg & ~reg_wdata[STS_ERR_MSB:STS_ERR_LSB];
      end
      err_sts_next = err_sts_next | err_detect;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_sts_reg <= ERR_STS_RST;
      end else begin
         err_sts_reg <= err_sts_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_mask_reg <= ERR_MASK_RST;
      end else if (wr_mask) begin
         err_mask_reg <= reg_wdata[STS_ERR_MSB:STS_ERR_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sequential_tag_debug_reg <= SEQUENTIAL_TAG_DEBUG_RST;
      end else if (wr_dbg) begin
         sequential_tag_debug_reg <= reg_wdata[DBG_SEQUENTIAL_TAG_DEBUG_BIT];
      end
   end

   // Hardwired fields are zero by construction of the read views.
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[CTL_UR_EN_BIT:CTL_CE_EN_BIT] = err_en_reg;
      ctrl_view[CTL_RO_BIT] = 1'b0;
      ctrl_view[CTL_MPS_MSB:CTL_MPS_LSB] = mps_reg;
      ctrl_view[CTL_ETAG_BIT] = etag_reg;
      ctrl_view[CTL_PHANTOM_FUNCTION_ENABLE_BIT] = 1'b0;
      ctrl_view[CTL_AUXPM_BIT] = 1'b0;
      ctrl_view[CTL_NS_BIT] = 1'b0;
      ctrl_view[CTL_MAX_READ_REQUEST_SIZE_MSB:CTL_MAX_READ_REQUEST_SIZE_LSB] = 3'h0;
      stat_view = 16'h0000;
      stat_view[STS_ERR_MSB:STS_ERR_LSB] = err_sts_reg;
      stat_view[STS_AUX_POWER_DETECTED_BIT] = 1'b0;
      stat_view[STS_TP_BIT] = 1'b0;
   end

   always_comb begin
      rdata_next = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_DEV_CTRL: begin
               rdata_next = ctrl_view;
            end
            OFF_DEV_STAT: begin
               rdata_next = stat_view;
            end
            OFF_ERR_MASK: begin
               rdata_next = {12'h000, err_mask_reg};
            end
            OFF_DBG_CTRL: begin
               rdata_next = {15'h0000, sequential_tag_debug_reg};
            end
            default: begin
               rdata_next = 16'h0000;
            end
         endcase
      end
   end

   // Read data is valid only in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= RDATA_RST;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // Reports go out only for enabled classes, while logging above is not.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_report_reg <= '0;
      end else begin
         err_report_reg <= err_detect & err_en_reg;
      end
   end

   assign err_report = err_report_reg;
   assign irq        = |(err_sts_reg & err_mask_reg);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mps_bytes_reg <= MPS_BASE;
      end else begin
         mps_bytes_reg <= pdcs_mps_bytes(mps_reg);
      end
   end

   assign max_payload_bytes = mps_bytes_reg;

   // Originated requests are fixed small and plain; the fields above
   // cannot widen them because nothing here ever reads those fields.
   assign orig_max_read_bytes   = ORIG_MAX_RD;
   assign orig_relaxed_ordering = 1'b0;
   assign orig_no_snoop         = 1'b0;

   // Passing transactions keep their attributes and size untouched.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fwd_valid_reg <= 1'b0;
         fwd_attr_reg  <= '0;
      end else begin
         fwd_valid_reg <= fwd_valid;
         fwd_attr_reg  <= fwd_attr_in;
      end
   end

   assign fwd_valid_out = fwd_valid_reg;
   assign fwd_attr_out  = fwd_attr_reg;

   pdcs_tag_gen u_tag_gen (
      .clk     (clk),
      .rst_n   (rst_n),
      .seq_en  (sequential_tag_debug_reg),
      .ext_en  (etag_reg),
      .advance (tag_advance),
      .tag     (tag)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Attempts that start on the release edge still see reset-time samples,
   // so properties that reach back into reset are guarded by rst_n.

   AST_EN_WRITE: assert property (
      wr_ctrl |=> err_en_reg == $past(reg_wdata[3:0]))
      else $error("Report enables did not take the written value.");

   AST_REPORT_GATED: assert property (
      rst_n |-> err_report == ($past(err_detect) & $past(err_en_reg)))
      else $error("Error report not gated by its enable.");

   AST_CTRL_FIXED_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_CTRL |=>
         reg_rdata[4] == 1'b0 && reg_rdata[15:9] == 7'h00)
      else $error("Hardwired control bits did not read zero.");

   AST_MPS_DECODE: assert property (
      rst_n && $past(mps_reg) <= 3'h4 |->
         max_payload_bytes == (12'h080 << $past(mps_reg)))
      else $error("Payload size decode is wrong.");

   AST_MPS_RESERVED: assert property (
      mps_reg >= 3'h5 ##1 mps_reg >= 3'h5 |-> max_payload_bytes == 12'h080)
      else $error("Reserved payload code not treated as 128 bytes.");

   AST_TAG_RANGE: assert property (
      sequential_tag_debug_reg && !etag_reg ##1 sequential_tag_debug_reg && !etag_reg |->
         tag <= 8'h1F)
      else $error("Tag left the short range.");

   AST_TAG_WRAP: assert property (
      sequential_tag_debug_reg && etag_reg && tag == 8'hFF && tag_advance
         ##1 sequential_tag_debug_reg && etag_reg |-> tag == 8'h00)
      else $error("Extended tag did not wrap to zero.");

   AST_TAG_STEP: assert property (
      sequential_tag_debug_reg && tag_advance && tag < 8'h1F ##1 sequential_tag_debug_reg |->
         tag == $past(tag) + 8'h01)
      else $error("Tag did not advance by one.");

   AST_ETAG_RW: assert property (
      wr_ctrl ##1 reg_rd && reg_addr == OFF_DEV_CTRL && !wr_ctrl |=>
         reg_rdata[8] == $past(reg_wdata[8], 2))
      else $error("Extended tag enable did not read back.");

   AST_ORIG_ATTR: assert property (
      orig_no_snoop == 1'b0 && orig_relaxed_ordering == 1'b0
         && orig_max_read_bytes == 12'h080)
      else $error("Originated request attributes not fixed.");

   AST_FWD_PASS: assert property (
      fwd_valid && rst_n |=> fwd_valid_out && fwd_attr_out == $past(fwd_attr_in))
      else $error("Forwarded attributes were altered.");

   AST_STS_SET_WINS: assert property (
      err_detect[0] |=> err_sts_reg[0])
      else $error("Detected correctable error was not logged.");

   AST_STS_W1C: assert property (
      wr_stat && reg_wdata[2] && !err_detect[2] |=> !err_sts_reg[2])
      else $error("Write one did not clear the status bit.");

   AST_STS_HOLD: assert property (
      err_sts_reg[3] && !(wr_stat && reg_wdata[3]) |=> err_sts_reg[3])
      else $error("Unsupported request flag lost without a clear.");

   AST_STAT_FIXED_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_STAT |=> reg_rdata[15:4] == 12'h000)
      else $error("Hardwired status bits did not read zero.");

   AST_IRQ_LEVEL: assert property (
      irq == ((err_sts_reg & err_mask_reg) != 4'h0))
      else $error("Interrupt level does not follow masked status.");

   AST_UNMAPPED_ZERO: assert property (
      reg_rd && reg_addr != OFF_DEV_CTRL && reg_addr != OFF_DEV_STAT
         && reg_addr != OFF_ERR_MASK && reg_addr != OFF_DBG_CTRL
         |=> reg_rdata == 16'h0000)
      else $error("Unmapped read did not return zero.");

   AST_PHANTOM_FUNCTION_ENABLE_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_CTRL |=> reg_rdata[9] == 1'b0)
      else $error("Phantom function enable did not read zero.");

   AST_AUXPM_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_CTRL |=> reg_rdata[10] == 1'b0)
      else $error("Aux power management enable did not read zero.");

   AST_NS_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_CTRL |=> reg_rdata[11] == 1'b0)
      else $error("No snoop enable did not read zero.");

   AST_MAX_READ_REQUEST_SIZE_ZERO: assert property (
      reg_rd && reg_addr == OFF_DEV_CTRL |=> reg_rdata[14:12] == 3'h0)
      else $error("Read request size field did not read zero.");

   AST_MPS_READBACK: assert property (
      wr_ctrl ##1 reg_rd && reg_addr == OFF_DEV_CTRL && !wr_ctrl |=>
         reg_rdata[7:5] == $past(reg_wdata[7:5], 2))
      else $error("Payload size field did not read back.");

   AST_CTRL_HOLD: assert property (
      !wr_ctrl |=> mps_reg == $past(mps_reg) && etag_reg == $past(etag_reg)
         && err_en_reg == $past(err_en_reg))
      else $error("Control field changed without a write.");

   AST_MASK_WRITE: assert property (
      wr_mask |=> err_mask_reg == $past(reg_wdata[3:0]))
      else $error("Error mask did not take the written value.");

   AST_TAG_IDLE_ZERO: assert property (
      !sequential_tag_debug_reg |=> tag == 8'h00)
      else $error("Tag moved while sequential tags were off.");

   AST_STS_NO_SPURIOUS: assert property (
      err_sts_reg == 4'h0 && err_detect == 4'h0 |=> err_sts_reg == 4'h0)
      else $error("Status bit set with no detected error.");

   AST_RDATA_IDLE_ZERO: assert property (
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("Read data did not return to zero after a read.");

endmodule : pdcs_regs

// >>> tb/pdcs_regs_bench.sv
// Self-checking testbench of the device control and status register bank.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module pdcs_regs_bench;
   import pdcs_pkg::*;
   logic                clk;
   logic                rst_n;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata;
   logic                reg_wr;
   logic                reg_rd;
   logic [DATA_W-1:0]   reg_rdata;
   pdcs_err_s           err_detect;
   pdcs_err_s           err_report;
   logic                irq;
   logic [11:0]         max_payload_bytes;
   logic [11:0]         orig_max_read_bytes;
   logic                orig_relaxed_ordering;
   logic                orig_no_snoop;
   logic                tag_advance;
   logic [7:0]          tag;
   logic                fwd_valid;
   pdcs_attr_s          fwd_attr_in;
   logic                fwd_valid_out;
   pdcs_attr_s          fwd_attr_out;
   int                  bad_count;
   int                  n_compared;
   int                  t_exp;
   logic [15:0]         d;
   // Each row is written data, read-back data and resulting payload bytes.
   logic [43:0]         rows [0:9] = '{
      {16'hFFFF, 16'h01EF, 12'h080}, {16'h0000, 16'h0000, 12'h080},
      {16'h0020, 16'h0020, 12'h100}, {16'h0040, 16'h0040, 12'h200},
      {16'h0060, 16'h0060, 12'h400}, {16'h0080, 16'h0080, 12'h800},
      {16'h00A0, 16'h00A0, 12'h080}, {16'h00C0, 16'h00C0, 12'h080},
      {16'h0110, 16'h0100, 12'h080}, {16'hFE0F, 16'h000F, 12'h080}};

   pdcs_regs u_pdcs_regs (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .err_detect            (err_detect),
      .err_report            (err_report),
      .irq                   (irq),
      .max_payload_bytes     (max_payload_bytes),
      .orig_max_read_bytes   (orig_max_read_bytes),
      .orig_relaxed_ordering (orig_relaxed_ordering),
      .orig_no_snoop         (orig_no_snoop),
      .tag_advance           (tag_advance),
      .tag                   (tag),
      .fwd_valid             (fwd_valid),
      .fwd_attr_in           (fwd_attr_in),
      .fwd_valid_out         (fwd_valid_out),
      .fwd_attr_out          (fwd_attr_out)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // The write strobe stays up into the next task so back-to-back cycles need no gap.
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
   endtask : wr

   task automatic idle();
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
   endtask : idle

   task automatic rd(input logic [11:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      reg_wr   <= 1'b0;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask : rd

   task automatic pulse(input logic [3:0] e);
      @(posedge clk);
      err_detect <= pdcs_err_s'(e);
      @(posedge clk);
      err_detect <= pdcs_err_s'(4'h0);
      @(negedge clk);
   endtask : pulse

   // Advance the debug tag n times; the bench keeps its own expected count.
   task automatic adv(input int n, input int lim);
      @(posedge clk);
      tag_advance <= 1'b1;
      for (int i = 1; i <= n; i++) begin
         @(posedge clk);
         if (i == n) begin
            tag_advance <= 1'b0;
         end
         @(negedge clk);
         t_exp = (t_exp + 1) % lim;
         `CHK(tag, 8'(t_exp))
      end
   endtask : adv

   task automatic fwd(input logic v, input logic [11:0] a);
      @(posedge clk);
      fwd_valid   <= v;
      fwd_attr_in <= pdcs_attr_s'(a);
      @(posedge clk);
      @(negedge clk);
      `CHK(fwd_valid_out, v)
      `CHK(fwd_attr_out, pdcs_attr_s'(a))
   endtask : fwd

   task automatic rst_chk();
      rd(OFF_DEV_CTRL, d);
      `CHK(d, 16'h0000)
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h0000)
      `CHK(max_payload_bytes, 12'h080)
      `CHK(tag, 8'h00)
      `CHK(irq, 1'b0)
   endtask : rst_chk

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end

   initial begin
      bad_count = 0;
      n_compared = 0;
      t_exp = 0;
      rst_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, tag_advance, fwd_valid} = '0;
      err_detect = pdcs_err_s'(4'h0);
      fwd_attr_in = pdcs_attr_s'(12'h000);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rst_chk();
      $display("test reset done");
      for (int r = 0; r < 10; r++) begin
         wr(OFF_DEV_CTRL, rows[r][43:28]);
         rd(OFF_DEV_CTRL, d);
         `CHK(d, rows[r][27:12])
         `CHK(max_payload_bytes, rows[r][11:0])
      end
      `CHK(orig_relaxed_ordering, 1'b0)
      `CHK(orig_no_snoop, 1'b0)
      `CHK(orig_max_read_bytes, 12'h080)
      $display("test control table done");
      wr(OFF_DEV_CTRL, 16'h0005);
      wr(OFF_ERR_MASK, 16'h0000);
      idle();
      pulse(4'hF);
      `CHK(err_report, pdcs_err_s'(4'h5))
      `CHK(irq, 1'b0)
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h000F)
      wr(OFF_ERR_MASK, 16'h0008);
      idle();
      `CHK(irq, 1'b1)
      rd(OFF_ERR_MASK, d);
      `CHK(d, 16'h0008)
      wr(OFF_DEV_STAT, 16'h0008);
      idle();
      `CHK(irq, 1'b0)
      wr(OFF_DEV_STAT, 16'hFFF0);
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h0007)
      wr(OFF_DEV_STAT, 16'h0007);
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h0000)
      // A detection on the edge of a clearing write must keep its bit.
      pulse(4'h9);
      wr(OFF_DEV_STAT, 16'h0009);
      err_detect <= pdcs_err_s'(4'h8);
      @(posedge clk);
      reg_wr     <= 1'b0;
      err_detect <= pdcs_err_s'(4'h0);
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h0008)
      `CHK(irq, 1'b1)
      wr(OFF_DEV_STAT, 16'h0008);
      rd(OFF_DEV_STAT, d);
      `CHK(d, 16'h0000)
      $display("test error status done");
      wr(12'h04C, 16'hFFFF);
      rd(12'h04C, d);
      `CHK(d, 16'h0000)
      rd(OFF_DEV_CTRL, d);
      `CHK(d, 16'h0005)
      @(negedge clk);
      `CHK(reg_rdata, 16'h0000)
      $display("test unmapped done");
      wr(OFF_DBG_CTRL, 16'h0001);
      wr(OFF_DEV_CTRL, 16'h0000);
      idle();
      rd(OFF_DBG_CTRL, d);
      `CHK(d, 16'h0001)
      adv(33, 32);
      wr(OFF_DEV_CTRL, 16'h0100);
      idle();
      adv(260, 256);
      adv(50, 256);
      // Dropping the limit below the current tag must restart from zero.
      wr(OFF_DEV_CTRL, 16'h0000);
      idle();
      @(negedge clk);
      `CHK(tag, 8'h00)
      wr(OFF_DBG_CTRL, 16'h0000);
      idle();
      t_exp = 0;
      adv(3, 1);
      $display("test tag done");
      fwd(1'b1, 12'hFFF);
      fwd(1'b0, 12'h001);
      fwd(1'b1, 12'h800);
      $display("test forward done");
      wr(OFF_DEV_CTRL, 16'h008F);
      idle();
      pulse(4'h8);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rst_chk();
      $display("test mid-run reset done");
      end_sim();
   end
endmodule : pdcs_regs_bench
